// >>> src/data_store.sv
`timescale 1ns/1ps
`default_nettype none
`include "exec_defs.svh"

// ----------------------------------------------------------------------------
// flip-flop data memory, one read and one write port
// ----------------------------------------------------------------------------
module data_store #(
    parameter int AW = 7
) (
    input  wire logic   mclk,
    input  wire logic   reset,
    exec_if.mem_side    port
);
    logic [`DATA_W-1:0] mem_reg [2**AW];

    // only the low bits of a 16-bit address select a cell; upper bits alias
    assign port.rd_data = mem_reg[port.rd_addr[AW-1:0]];

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            for (int i = 0; i < 2**AW; i++) begin
                mem_reg[i] <= '0;
            end
        end else if (port.wr_en) begin
            mem_reg[port.wr_addr[AW-1:0]] <= port.wr_data;
        end
    end
endmodule : data_store

`default_nettype wire

// >>> src/exec_defs.svh
`ifndef EXEC_DEFS_SVH
`define EXEC_DEFS_SVH

// ----------------------------------------------------------------------------
// register byte offsets on the apb side
// ----------------------------------------------------------------------------
`define OFF_CMD        8'h00
`define OFF_STATUS     8'h04
`define OFF_WREG       8'h08
`define OFF_PTR0       8'h0C
`define OFF_PTR1       8'h10
`define OFF_MEM_ADDR   8'h14
`define OFF_MEM_DATA   8'h18

// ----------------------------------------------------------------------------
// status bit positions and widths
// ----------------------------------------------------------------------------
`define STAT_BUSY_BIT  0
`define STAT_C_BIT     1
`define STAT_Z_BIT     2
`define PTR_W          16
`define DATA_W         8
`define FADDR_W        7

// ----------------------------------------------------------------------------
// reset values and fixed addresses
// ----------------------------------------------------------------------------
`define WREG_RST       8'h00
`define PTR_RST        16'h0000
`define PTR_ONE        16'h0001
`define INDF0_FADDR    7'h00
`define INDF1_FADDR    7'h01

`endif

// >>> src/exec_if.sv
`timescale 1ns/1ps
`default_nettype none
`include "exec_defs.svh"

// ----------------------------------------------------------------------------
// carrier between the core, the data store and the pointer arithmetic
// ----------------------------------------------------------------------------
interface exec_if;
    logic [`PTR_W-1:0]  rd_addr;
    logic [`DATA_W-1:0] rd_data;
    logic               wr_en;
    logic [`PTR_W-1:0]  wr_addr;
    logic [`DATA_W-1:0] wr_data;
    logic [`PTR_W-1:0]  ptr_in;
    logic [1:0]         mode;
    logic               relative;
    logic [5:0]         offset;
    logic [`PTR_W-1:0]  eff_addr;
    logic [`PTR_W-1:0]  ptr_next;

    modport core (output rd_addr, wr_en, wr_addr, wr_data, ptr_in, mode, relative, offset,
                  input  rd_data, eff_addr, ptr_next);
    modport mem_side (input rd_addr, wr_en, wr_addr, wr_data, output rd_data);
    modport ptr_side (input ptr_in, mode, relative, offset, output eff_addr, ptr_next);
endinterface : exec_if

`default_nettype wire

// >>> src/exec_pkg.sv
`include "exec_defs.svh"

package exec_pkg;

    // operation selected by the command word
    typedef enum logic [1:0] {
        LOGICAL_SHIFT_LEFT_OP  = 2'h0,
        LOGICAL_SHIFT_RIGHT_OP = 2'h1,
        FILE_MOVE_OP           = 2'h2,
        INDIRECT_LOAD_OP       = 2'h3
    } op_t;

    // pointer_update_code values for the indirect load
    typedef enum logic [1:0] {
        PRE_INC  = 2'h0,
        PRE_DEC  = 2'h1,
        POST_INC = 2'h2,
        POST_DEC = 2'h3
    } pointer_update_code_t;

    // execution sequencer, gray along idle -> exec -> idle
    typedef enum logic [0:0] {
        ST_IDLE = 1'h0,
        ST_EXEC = 1'h1
    } state_t;

    // command word as written to the command register, high bits first
    typedef struct packed {
        logic [5:0]           offset;
        logic                 relative;
        pointer_update_code_t mode;
        logic                 ptr_n;
        logic [6:0]           faddr;
        logic                 dest;
        op_t                  op;
    } cmd_t;

endpackage : exec_pkg

// >>> src/pointer_calc.sv
`timescale 1ns/1ps
`default_nettype none
`include "exec_defs.svh"

// ----------------------------------------------------------------------------
// effective address and pointer write-back for the indirect load
// ----------------------------------------------------------------------------
module pointer_calc
    import exec_pkg::*;
(
    exec_if.ptr_side port
);
    // 16-bit add that wraps, never saturates
    function automatic logic [`PTR_W-1:0] wrap_add(input logic [`PTR_W-1:0] a,
                                                   input logic [`PTR_W-1:0] b);
        wrap_add = `PTR_W'(a + b);
    endfunction : wrap_add

    wire logic [`PTR_W-1:0] p_inc  = wrap_add(port.ptr_in, `PTR_ONE);
    wire logic [`PTR_W-1:0] p_dec  = `PTR_W'(port.ptr_in - `PTR_ONE);
    wire logic [`PTR_W-1:0] off_sx = `PTR_W'($signed(port.offset));
    wire logic [`PTR_W-1:0] p_rel  = wrap_add(port.ptr_in, off_sx);

    // relative offset leaves the pointer alone; pre modes keep the modified value
    always_comb begin
        if (port.relative) begin
            port.eff_addr = p_rel;
            port.ptr_next = port.ptr_in;
        end else begin
            case (pointer_update_code_t'(port.mode))
                PRE_INC: begin
                    port.eff_addr = p_inc;
                    port.ptr_next = p_inc;
                end
                PRE_DEC: begin
                    port.eff_addr = p_dec;
                    port.ptr_next = p_dec;
                end
                POST_INC: begin
                    port.eff_addr = port.ptr_in;
                    port.ptr_next = p_inc;
                end
                POST_DEC: begin
                    port.eff_addr = port.ptr_in;
                    port.ptr_next = p_dec;
                end
                default: begin
                    port.eff_addr = port.ptr_in;
                    port.ptr_next = port.ptr_in;
                end
            endcase
        end
    end
endmodule : pointer_calc

`default_nettype wire

// >>> src/shift_move_indirect_exec.sv
// Added by the designer: register access over APB and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "exec_defs.svh"

module shift_move_indirect_exec
    import exec_pkg::*;
#(
    parameter int DMEM_AW = 7
) (
    input  wire logic        mclk,
    input  wire logic        reset,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic             pslverr,
    output logic [31:0]      prdata
);
    // ------------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------------
    state_t                   state_reg;
    cmd_t                     cmd_reg;
    logic [`DATA_W-1:0]       w_reg;
    logic                     c_reg;
    logic                     z_reg;
    logic [`PTR_W-1:0]        ptr_reg [2];
    logic [`FADDR_W-1:0]      maddr_reg;
    logic                     pready_reg;
    logic                     pslverr_reg;
    logic [31:0]              prdata_reg;

    exec_if bus ();

    data_store #(.AW(DMEM_AW)) i_data_store (
        .mclk  (mclk),
        .reset (reset),
        .port  (bus.mem_side)
    );

    pointer_calc i_pointer_calc (
        .port (bus.ptr_side)
    );

    // ------------------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------------------
    // the answer comes one cycle into the access phase so that read data is
    // taken from a flip-flop, never through the decode path
    wire logic apb_access = psel & penable & ~pready_reg;
    wire logic apb_done   = psel & penable & pready_reg;
    wire logic busy       = (state_reg != ST_IDLE);
    wire logic hit_cmd    = (paddr == `OFF_CMD);
    wire logic hit_status = (paddr == `OFF_STATUS);
    wire logic hit_wreg   = (paddr == `OFF_WREG);
    wire logic hit_ptr0   = (paddr == `OFF_PTR0);
    wire logic hit_ptr1   = (paddr == `OFF_PTR1);
    wire logic hit_maddr  = (paddr == `OFF_MEM_ADDR);
    wire logic hit_mdata  = (paddr == `OFF_MEM_DATA);
    wire logic mapped     = hit_cmd | hit_status | hit_wreg | hit_ptr0 | hit_ptr1
                          | hit_maddr | hit_mdata;
    // launching or touching memory while a command runs would race the datapath
    wire logic refuse     = ~mapped | (busy & (hit_cmd | hit_mdata | hit_wreg
                          | hit_ptr0 | hit_ptr1 | hit_status));
    wire logic wr_ok      = apb_done & pwrite & ~pslverr_reg;
    wire logic launch     = wr_ok & hit_cmd;

    // ------------------------------------------------------------------------
    // operand addressing
    // ------------------------------------------------------------------------
    // the two lowest file addresses are the indirect data ports; they have
    // no cell of their own and are steered through the matching pointer
    wire logic               file_is_port = (cmd_reg.faddr == `INDF0_FADDR)
                                          | (cmd_reg.faddr == `INDF1_FADDR);
    wire logic [`PTR_W-1:0]  cur_ptr      = ptr_reg[cmd_reg.ptr_n];
    wire logic [`PTR_W-1:0]  file_addr    = file_is_port ? ptr_reg[cmd_reg.faddr[0]]
                                          : `PTR_W'(cmd_reg.faddr);
    wire logic               is_ind       = (cmd_reg.op == INDIRECT_LOAD_OP);
    wire logic               is_lsl       = (cmd_reg.op == LOGICAL_SHIFT_LEFT_OP);
    wire logic               is_lsr       = (cmd_reg.op == LOGICAL_SHIFT_RIGHT_OP);
    wire logic               exec         = (state_reg == ST_EXEC);

    assign bus.ptr_in   = cur_ptr;
    assign bus.mode     = cmd_reg.mode;
    assign bus.relative = cmd_reg.relative;
    assign bus.offset   = cmd_reg.offset;
    assign bus.rd_addr  = !exec ? `PTR_W'(maddr_reg)
                        : is_ind ? bus.eff_addr
                        : file_addr;

    // ------------------------------------------------------------------------
    // result and flags
    // ------------------------------------------------------------------------
    wire logic [`DATA_W-1:0] opnd   = bus.rd_data;
    wire logic [`DATA_W-1:0] result = is_lsl ? {opnd[`DATA_W-2:0], 1'b0}
                                    : is_lsr ? {1'b0, opnd[`DATA_W-1:1]}
                                    : opnd;
    wire logic               c_new  = is_lsl ? opnd[`DATA_W-1] : opnd[0];
    wire logic               z_new  = (result == '0);
    wire logic               to_w   = is_ind | ~cmd_reg.dest;

    // write-back into the file register, or memory load over apb
    assign bus.wr_en   = (exec & ~to_w) | (wr_ok & hit_mdata);
    assign bus.wr_addr = exec ? file_addr : `PTR_W'(maddr_reg);
    assign bus.wr_data = exec ? result : pwdata[`DATA_W-1:0];

    // read data mux for the apb answer
    wire logic [31:0] rd_mux =
          hit_cmd    ? 32'(cmd_reg)
        : hit_status ? 32'({z_reg, c_reg, busy})
        : hit_wreg   ? 32'(w_reg)
        : hit_ptr0   ? 32'(ptr_reg[0])
        : hit_ptr1   ? 32'(ptr_reg[1])
        : hit_maddr  ? 32'(maddr_reg)
        : hit_mdata  ? 32'(opnd)
        : 32'h0000_0000;

    // ------------------------------------------------------------------------
    // apb answer flops
    // ------------------------------------------------------------------------
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg  <= 32'h0000_0000;
        end else begin
            pready_reg  <= apb_access;
            pslverr_reg <= apb_access & refuse;
            if (apb_access & ~pwrite & ~refuse) begin
                prdata_reg <= rd_mux;
            end
        end
    end

    // ------------------------------------------------------------------------
    // sequencer and command capture
    // ------------------------------------------------------------------------
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            state_reg <= ST_IDLE;
            cmd_reg   <= '0;
            maddr_reg <= '0;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    if (launch) begin
                        state_reg <= ST_EXEC;
                    end
                end
                ST_EXEC: begin
                    state_reg <= ST_IDLE;
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
            if (launch) begin
                cmd_reg <= cmd_t'(pwdata[$bits(cmd_t)-1:0]);
            end
            if (wr_ok & hit_maddr) begin
                maddr_reg <= pwdata[`FADDR_W-1:0];
            end
        end
    end

    // ------------------------------------------------------------------------
    // working register and flags
    // ------------------------------------------------------------------------
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            w_reg <= `WREG_RST;
            c_reg <= 1'b0;
            z_reg <= 1'b0;
        end else if (exec) begin
            if (to_w) begin
                w_reg <= result;
            end
            if (is_lsl | is_lsr) begin
                c_reg <= c_new; // carry held on moves and loads
            end
            z_reg <= z_new;
        end else begin
            if (wr_ok & hit_wreg) begin
                w_reg <= pwdata[`DATA_W-1:0];
            end
            if (wr_ok & hit_status) begin
                c_reg <= pwdata[`STAT_C_BIT];
                z_reg <= pwdata[`STAT_Z_BIT];
            end
        end
    end

    // ------------------------------------------------------------------------
    // pointers
    // ------------------------------------------------------------------------
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            ptr_reg[0] <= `PTR_RST;
            ptr_reg[1] <= `PTR_RST;
        end else if (exec & is_ind) begin
            ptr_reg[cmd_reg.ptr_n] <= bus.ptr_next;
        end else begin
            if (wr_ok & hit_ptr0) begin
                ptr_reg[0] <= pwdata[`PTR_W-1:0];
            end
            if (wr_ok & hit_ptr1) begin
                ptr_reg[1] <= pwdata[`PTR_W-1:0];
            end
        end
    end

    // outputs straight from flops, so the bus sees no decode glitches
    assign pready  = pready_reg;
    assign pslverr = pslverr_reg;
    assign prdata  = prdata_reg;

    // ------------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);

    // datapath results land one edge after the exec cycle
    property p_lsl;
        exec && is_lsl && !cmd_reg.dest |=>
            w_reg == {$past(opnd[6:0]), 1'b0} && c_reg == $past(opnd[7]);
    endproperty
    a_lsl: assert property (p_lsl)
        else $error("left shift result or carry wrong");

    property p_lsr;
        exec && is_lsr && !cmd_reg.dest |=>
            w_reg == {1'b0, $past(opnd[7:1])} && c_reg == $past(opnd[0]);
    endproperty
    a_lsr: assert property (p_lsr)
        else $error("right shift result or carry wrong");

    property p_dest_file;
        exec && !is_ind && cmd_reg.dest |-> bus.wr_en && bus.wr_addr == file_addr
            ##1 $stable(w_reg);
    endproperty
    a_dest_file: assert property (p_dest_file)
        else $error("file write-back missing");

    property p_move_zero;
        exec && cmd_reg.op == FILE_MOVE_OP |=> z_reg == ($past(opnd) == 8'h00);
    endproperty
    a_move_zero: assert property (p_move_zero)
        else $error("move zero flag wrong");

    property p_move_w;
        exec && cmd_reg.op == FILE_MOVE_OP && !cmd_reg.dest |=> w_reg == $past(opnd);
    endproperty
    a_move_w: assert property (p_move_w)
        else $error("move result lost");

    property p_ind_load;
        exec && is_ind |=> w_reg == $past(opnd) && z_reg == ($past(opnd) == 8'h00);
    endproperty
    a_ind_load: assert property (p_ind_load)
        else $error("indirect load wrong");

    property p_redirect;
        exec && !is_ind && cmd_reg.faddr[6:1] == 6'h00 |->
            bus.rd_addr == ptr_reg[cmd_reg.faddr[0]];
    endproperty
    a_redirect: assert property (p_redirect)
        else $error("data port not redirected");

    property p_pre_inc;
        exec && is_ind && !cmd_reg.relative && cmd_reg.mode == PRE_INC |->
            bus.rd_addr == 16'(cur_ptr + 16'h0001) ##1 cur_ptr == $past(bus.rd_addr);
    endproperty
    a_pre_inc: assert property (p_pre_inc)
        else $error("pre-increment wrong");

    property p_pre_dec;
        exec && is_ind && !cmd_reg.relative && cmd_reg.mode == PRE_DEC |->
            bus.rd_addr == 16'(cur_ptr - 16'h0001) ##1 cur_ptr == $past(bus.rd_addr);
    endproperty
    a_pre_dec: assert property (p_pre_dec)
        else $error("pre-decrement wrong");

    property p_post_dec;
        exec && is_ind && !cmd_reg.relative && cmd_reg.mode == POST_DEC |->
            bus.rd_addr == cur_ptr ##1 cur_ptr == 16'($past(cur_ptr) - 16'h0001);
    endproperty
    a_post_dec: assert property (p_post_dec)
        else $error("post-decrement wrong");

    property p_post_inc;
        exec && is_ind && !cmd_reg.relative && cmd_reg.mode == POST_INC |->
            bus.rd_addr == cur_ptr ##1 cur_ptr == 16'($past(cur_ptr) + 16'h0001);
    endproperty
    a_post_inc: assert property (p_post_inc)
        else $error("post-increment wrong");

    property p_relative;
        exec && is_ind && cmd_reg.relative |->
            bus.rd_addr == 16'(cur_ptr + 16'($signed(cmd_reg.offset))) ##1 $stable(cur_ptr);
    endproperty
    a_relative: assert property (p_relative)
        else $error("relative address wrong");

    property p_no_carry;
        exec && is_ind |=> $stable(c_reg);
    endproperty
    a_no_carry: assert property (p_no_carry)
        else $error("carry touched by load");

    property p_apb_answer;
        psel && penable && !pready |=> pready ##1 !pready;
    endproperty
    a_apb_answer: assert property (p_apb_answer)
        else $error("apb answer late");

    c_lsl:  cover property (exec && is_lsl && cmd_reg.dest);
    c_lsr:  cover property (exec && is_lsr && !cmd_reg.dest);
    c_move: cover property (exec && cmd_reg.op == FILE_MOVE_OP && file_is_port);
    c_wrap: cover property (exec && is_ind && cur_ptr == 16'hFFFF && cmd_reg.mode == POST_INC);
    c_pre_dec: cover property (exec && is_ind && cmd_reg.mode == PRE_DEC);

endmodule : shift_move_indirect_exec

`default_nettype wire

// >>> verif/apb_master_model.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------------------
// apb master standing in for the decoder side
// ----------------------------------------------------------------------------
module apb_master_model (
    input  wire logic        mclk,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [7:0]       paddr,
    output logic [31:0]      pwdata,
    input  wire logic        pready,
    input  wire logic        pslverr,
    input  wire logic [31:0] prdata
);
    // idle bus at time zero
    initial begin
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 8'h00;
        pwdata  = 32'h0000_0000;
    end

    // one transfer; address and data are inverted on release so stale values never match
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic err);
        @(posedge mclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        while (pready !== 1'b1) @(posedge mclk);
        q = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        paddr   <= ~a;
        pwdata  <= ~d;
    endtask : xfer
endmodule : apb_master_model

`default_nettype wire

// >>> verif/shift_move_indirect_exec_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "exec_defs.svh"

module shift_move_indirect_exec_test
    import exec_pkg::*;
;
    logic        mclk;
    logic        reset;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
    int          n_fail;
    int          tests_run;

    // ------------------------------------------------------------------------
    // clock, design and bus master
    // ------------------------------------------------------------------------
    initial mclk = 1'b0;
    always #2 mclk = ~mclk;

    shift_move_indirect_exec #(.DMEM_AW(7)) i_shift_move_indirect_exec (
        .mclk(mclk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata));

    apb_master_model bus_master (
        .mclk(mclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata));

    // ------------------------------------------------------------------------
    // shared helpers
    // ------------------------------------------------------------------------
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask : check

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic        e;
        bus_master.xfer(1'b1, a, d, q, e);
        check("write error", 32'h0, {31'h0, e});
    endtask : wr

    task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        logic        e;
        bus_master.xfer(1'b0, a, 32'h0, q, e);
        check("read error", 32'h0, {31'h0, e});
        check(what, exp, q);
    endtask : rdchk

    // command word built field by field from the package layout
    function automatic logic [31:0] mk(op_t op, logic d, logic [6:0] f, logic n = 1'b0,
        logic [1:0] m = 2'h0, logic rel = 1'b0, logic [5:0] off = 6'h00);
        cmd_t c;
        c = '{offset: off, relative: rel, mode: pointer_update_code_t'(m), ptr_n: n,
              faddr: f, dest: d, op: op};
        return {12'h000, c};
    endfunction : mk

    task automatic setmem(input logic [6:0] i, input logic [7:0] v);
        wr(`OFF_MEM_ADDR, {25'h0, i});
        wr(`OFF_MEM_DATA, {24'h0, v});
    endtask : setmem

    task automatic memchk(input logic [6:0] i, input logic [7:0] v);
        wr(`OFF_MEM_ADDR, {25'h0, i});
        rdchk("cell", `OFF_MEM_DATA, {24'h0, v});
    endtask : memchk

    task automatic flags(input logic c, input logic z);
        rdchk("flags", `OFF_STATUS, {29'h0, z, c, 1'b0});
    endtask : flags

    // ------------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------------
    task automatic t_reset;
        logic [31:0] q;
        logic        e;
        rdchk("wreg", `OFF_WREG, 32'h0);
        flags(1'b0, 1'b0);
        rdchk("ptr0", `OFF_PTR0, 32'h0);
        bus_master.xfer(1'b0, 8'h1C, 32'h0, q, e);
        check("unmapped error", 32'h1, {31'h0, e});
    endtask : t_reset

    task automatic t_shift;
        setmem(7'h05, 8'h81);
        wr(`OFF_CMD, mk(LOGICAL_SHIFT_LEFT_OP, 1'b0, 7'h05));
        rdchk("wreg", `OFF_WREG, 32'h02);
        flags(1'b1, 1'b0);
        memchk(7'h05, 8'h81);
        setmem(7'h06, 8'h80);
        wr(`OFF_CMD, mk(LOGICAL_SHIFT_LEFT_OP, 1'b1, 7'h06));
        memchk(7'h06, 8'h00);
        flags(1'b1, 1'b1);
        setmem(7'h07, 8'h01);
        wr(`OFF_CMD, mk(LOGICAL_SHIFT_RIGHT_OP, 1'b0, 7'h07));
        rdchk("wreg", `OFF_WREG, 32'h00);
        flags(1'b1, 1'b1);
        setmem(7'h08, 8'hFE);
        wr(`OFF_CMD, mk(LOGICAL_SHIFT_RIGHT_OP, 1'b1, 7'h08));
        memchk(7'h08, 8'h7F);
        flags(1'b0, 1'b0);
    endtask : t_shift

    task automatic t_move;
        setmem(7'h09, 8'h00);
        wr(`OFF_WREG, 32'h55);
        wr(`OFF_STATUS, 32'h2);
        wr(`OFF_CMD, mk(FILE_MOVE_OP, 1'b1, 7'h09));
        rdchk("wreg", `OFF_WREG, 32'h55);
        memchk(7'h09, 8'h00);
        flags(1'b1, 1'b1);
        setmem(7'h0A, 8'hA5);
        wr(`OFF_CMD, mk(FILE_MOVE_OP, 1'b0, 7'h0A));
        rdchk("wreg", `OFF_WREG, 32'hA5);
        flags(1'b1, 1'b0);
    endtask : t_move

    // all four update codes around pointer 0010h, carry preset to show it is kept
    task automatic t_indirect;
        logic [7:0]  ew [4] = '{8'h33, 8'h11, 8'h22, 8'h22};
        logic [15:0] ep [4] = '{16'h0011, 16'h000F, 16'h0011, 16'h000F};
        setmem(7'h0F, 8'h11);
        setmem(7'h10, 8'h22);
        setmem(7'h11, 8'h33);
        for (int m = 0; m < 4; m++) begin
            wr(`OFF_PTR0, 32'h0010);
            wr(`OFF_STATUS, 32'h6);
            wr(`OFF_CMD, mk(INDIRECT_LOAD_OP, 1'b0, 7'h00, 1'b0, m[1:0]));
            rdchk("wreg", `OFF_WREG, {24'h0, ew[m]});
            rdchk("ptr0", `OFF_PTR0, {16'h0, ep[m]});
            flags(1'b1, 1'b0);
        end
    endtask : t_indirect

    task automatic t_relative;
        setmem(7'h00, 8'h00);
        setmem(7'h3F, 8'h5A);
        wr(`OFF_PTR1, 32'h0020);
        wr(`OFF_CMD, mk(INDIRECT_LOAD_OP, 1'b0, 7'h00, 1'b1, 2'h0, 1'b1, 6'h1F));
        rdchk("wreg", `OFF_WREG, 32'h5A);
        wr(`OFF_CMD, mk(INDIRECT_LOAD_OP, 1'b0, 7'h00, 1'b1, 2'h3, 1'b1, 6'h20));
        rdchk("wreg", `OFF_WREG, 32'h00);
        flags(1'b1, 1'b1);
        rdchk("ptr1", `OFF_PTR1, 32'h0020);
    endtask : t_relative

    task automatic t_wrap;
        setmem(7'h7F, 8'hC3);
        wr(`OFF_PTR0, 32'hFFFF);
        wr(`OFF_CMD, mk(INDIRECT_LOAD_OP, 1'b0, 7'h00, 1'b0, 2'h2));
        rdchk("wreg", `OFF_WREG, 32'hC3);
        rdchk("ptr0", `OFF_PTR0, 32'h0000);
        wr(`OFF_CMD, mk(INDIRECT_LOAD_OP, 1'b0, 7'h00, 1'b0, 2'h1));
        rdchk("ptr0", `OFF_PTR0, 32'hFFFF);
    endtask : t_wrap

    // file addresses 0 and 1 must reach the cell the pointer names, not a register
    task automatic t_indf;
        wr(`OFF_PTR1, 32'h0042);
        setmem(7'h42, 8'h9C);
        wr(`OFF_CMD, mk(FILE_MOVE_OP, 1'b0, 7'h01));
        rdchk("wreg", `OFF_WREG, 32'h9C);
        wr(`OFF_PTR0, 32'h0043);
        setmem(7'h43, 8'h40);
        wr(`OFF_CMD, mk(LOGICAL_SHIFT_LEFT_OP, 1'b1, 7'h00));
        memchk(7'h43, 8'h80);
        rdchk("ptr0", `OFF_PTR0, 32'h0043);
    endtask : t_indf

    // ------------------------------------------------------------------------
    // sequence, watchdog and verdict
    // ------------------------------------------------------------------------
    task automatic stop_test;
        $display("comparisons %0d, mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : stop_test

    // the whole run needs well under a thousand transfers
    initial begin
        repeat (20000) @(posedge mclk);
        n_fail++;
        $display("unexpected timeout: expected end of tests, seen none");
        stop_test();
    end

    initial begin
        n_fail = 0;
        tests_run = 0;
        reset = 1'b1;
        repeat (2) @(posedge mclk);
        reset <= 1'b0;
        t_reset();
        t_shift();
        t_move();
        t_indirect();
        t_relative();
        t_wrap();
        t_indf();
        stop_test();
    end
endmodule : shift_move_indirect_exec_test

`default_nettype wire
